// ---- sdp_params.svh ----
// constants for the two-wire dac slave port
`ifndef SDP_PARAMS_SVH
`define SDP_PARAMS_SVH
`define SDP_SLAVE_ADDR   7'h48
`define SDP_CMD_DATA     8'h00
`define SDP_CMD_CFG      8'h01
`define SDP_BYTE_BITS    4'h8
`define SDP_CNT_ZERO     4'h0
`define SDP_CNT_ONE      4'h1
`define SDP_DATA_RST     8'h00
`define SDP_CFG_RST      1'h0
`define SDP_CFG_STBY_BIT 0
`define SDP_CFG_RSVD     7'h00
`define SDP_LINE_IDLE    1'h1
`define SDP_READ_ZERO    8'h00
`define SDP_BIT_CLR      1'h0
`define SDP_RW_BIT       0
`endif

// ---- sdp_pkg.sv ----
// types shared by the two-wire dac slave port
package sdp_pkg;
    typedef enum logic [3:0] {
        SDP_IDLE      = 4'h0,
        SDP_ADDR      = 4'h1,
        SDP_ADDR_ACK  = 4'h2,
        SDP_CMD       = 4'h3,
        SDP_CMD_ACK   = 4'h4,
        SDP_WDATA     = 4'h5,
        SDP_WDATA_ACK = 4'h6,
        SDP_RDATA     = 4'h7,
        SDP_RDATA_ACK = 4'h8,
        SDP_IGNORE    = 4'h9
    } sdp_state_type;
endpackage

// ---- sdp_slave.sv ----
// two-wire slave port with data and configuration registers
// Overview of operation
// - idle until start seen on lines
// - stop ends transfer, back to waiting
// - acknowledge only own seven-bit address
// - eighth address bit one means read
// - device pulls data low on ninth clock
// - receiver holds data low during ack high
// - data changes only while clock low
// - all bytes shifted most significant first
// - device never drives clock, slave only
// - acknowledge each byte written into register
// - command 00h data, 01h configuration
// - lines released while bus idle
// - read after repeated start, master nacks
// - both registers cleared at reset
`timescale 1ns/100ps
`include "sdp_params.svh"

module sdp_slave (
    input  wire logic                  mclk,
    input  wire logic                  rst_b,
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe,
    output logic [7:0]                 conv_value,
    output logic                       standby,
    output sdp_pkg::sdp_state_type     xfer_state
);
    import sdp_pkg::*;

    sdp_state_type state_reg;
    sdp_state_type state_next;
    logic [3:0]    cnt_reg;
    logic [3:0]    cnt_next;
    logic [7:0]    sh_reg;
    logic [7:0]    sh_next;
    logic [7:0]    cmd_reg;
    logic [7:0]    cmd_next;
    logic          rw_reg;
    logic          rw_next;
    logic          mack_reg;
    logic          mack_next;
    logic          oe_reg;
    logic          oe_next;
    logic [7:0]    data_reg;
    logic [7:0]    data_next;
    logic          stby_reg;
    logic          stby_next;
    logic          sda_out_reg;
    wire  [1:0]    pin_in;
    wire  [1:0]    sync_bus;
    wire  [1:0]    prev_bus;
    wire           scl_s;
    wire           sda_s;
    wire           scl_p;
    wire           sda_p;
    wire           scl_rise;
    wire           scl_fall;
    wire           start_det;
    wire           stop_det;
    wire           byte_done;
    wire           addr_hit;
    wire           cmd_ok;
    wire  [7:0]    read_value;

    function automatic logic sdp_reg_valid(input logic [7:0] cmd);
        sdp_reg_valid = (cmd == `SDP_CMD_DATA) || (cmd == `SDP_CMD_CFG);
    endfunction

    assign pin_in = {scl_in, sda_in};

    // lines idle high, so the sync chain resets high too
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            logic meta_reg;
            logic sync_reg;
            logic prev_reg;
            always_ff @(posedge mclk) begin
                if (!rst_b) begin
                    meta_reg <= `SDP_LINE_IDLE;
                    sync_reg <= `SDP_LINE_IDLE;
                    prev_reg <= `SDP_LINE_IDLE;
                end else begin
                    meta_reg <= pin_in[g];
                    sync_reg <= meta_reg;
                    prev_reg <= sync_reg;
                end
            end
            assign sync_bus[g] = sync_reg;
            assign prev_bus[g] = prev_reg;
        end
    endgenerate

    assign scl_s     = sync_bus[1];
    assign sda_s     = sync_bus[0];
    assign scl_p     = prev_bus[1];
    assign sda_p     = prev_bus[0];
    assign scl_rise  = scl_s & ~scl_p;
    assign scl_fall  = ~scl_s & scl_p;
    assign start_det = scl_s & scl_p & sda_p & ~sda_s;
    assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;
    assign byte_done = (cnt_reg == `SDP_BYTE_BITS);
    assign addr_hit  = (sh_reg[7:1] == `SDP_SLAVE_ADDR);
    assign cmd_ok    = sdp_reg_valid(cmd_reg);
    assign read_value = !sdp_reg_valid(cmd_reg) ? `SDP_READ_ZERO :
                        (cmd_reg == `SDP_CMD_CFG) ?
                        {`SDP_CFG_RSVD, stby_reg} : data_reg;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        sh_next    = sh_reg;
        cmd_next   = cmd_reg;
        rw_next    = rw_reg;
        mack_next  = mack_reg;
        oe_next    = oe_reg;
        data_next  = data_reg;
        stby_next  = stby_reg;
        if (stop_det) begin
            state_next = SDP_IDLE;
            oe_next    = 1'b0;
        end else if (start_det) begin
            // start or repeated start opens address
            state_next = SDP_ADDR;
            cnt_next   = `SDP_CNT_ZERO;
            oe_next    = 1'b0;
        end else begin
            case (state_reg)
                SDP_ADDR, SDP_CMD, SDP_WDATA: begin
                    if (scl_rise) begin
                        sh_next  = {sh_reg[6:0], sda_s};
                        cnt_next = cnt_reg + `SDP_CNT_ONE;
                    end else if (scl_fall && byte_done) begin
                        cnt_next = `SDP_CNT_ZERO;
                        if (state_reg == SDP_ADDR) begin
                            if (addr_hit) begin
                                state_next = SDP_ADDR_ACK;
                                oe_next    = 1'b1;
                                rw_next    = sh_reg[`SDP_RW_BIT];
                            end else begin
                                state_next = SDP_IGNORE;
                                oe_next    = 1'b0;
                            end
                        end else if (state_reg == SDP_CMD) begin
                            cmd_next   = sh_reg;
                            state_next = SDP_CMD_ACK;
                            oe_next    = 1'b1;
                        end else if (cmd_ok) begin
                            if (cmd_reg == `SDP_CMD_DATA) begin
                                data_next = sh_reg;
                            end else begin
                                stby_next = sh_reg[`SDP_CFG_STBY_BIT];
                            end
                            state_next = SDP_WDATA_ACK;
                            oe_next    = 1'b1;
                        end else begin
                            state_next = SDP_IGNORE;
                            oe_next    = 1'b0;
                        end
                    end
                end
                SDP_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_next = `SDP_CNT_ZERO;
                        // direction bit picks read or write
                        if (rw_reg) begin
                            state_next = SDP_RDATA;
                            sh_next    = read_value;
                            oe_next    = ~read_value[7];
                        end else begin
                            state_next = SDP_CMD;
                            oe_next    = 1'b0;
                        end
                    end
                end
                SDP_CMD_ACK, SDP_WDATA_ACK: begin
                    if (scl_fall) begin
                        state_next = SDP_WDATA;
                        oe_next    = 1'b0;
                        cnt_next   = `SDP_CNT_ZERO;
                    end
                end
                SDP_RDATA: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + `SDP_CNT_ONE;
                    end else if (scl_fall) begin
                        if (byte_done) begin
                            state_next = SDP_RDATA_ACK;
                            oe_next    = 1'b0;
                            cnt_next   = `SDP_CNT_ZERO;
                        end else begin
                            // next bit set up on falling clock
                            sh_next = {sh_reg[6:0], 1'b0};
                            oe_next = ~sh_reg[6];
                        end
                    end
                end
                SDP_RDATA_ACK: begin
                    if (scl_rise) begin
                        mack_next = ~sda_s;
                    end else if (scl_fall) begin
                        if (mack_reg) begin
                            state_next = SDP_RDATA;
                            sh_next    = read_value;
                            oe_next    = ~read_value[7];
                        end else begin
                            state_next = SDP_IGNORE;
                        end
                    end
                end
                SDP_IDLE, SDP_IGNORE: begin
                    oe_next = 1'b0;
                end
                default: begin
                    state_next = SDP_IDLE;
                    oe_next    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_reg   <= SDP_IDLE;
            cnt_reg     <= `SDP_CNT_ZERO;
            sh_reg      <= `SDP_DATA_RST;
            cmd_reg     <= `SDP_CMD_DATA;
            rw_reg      <= `SDP_BIT_CLR;
            mack_reg    <= `SDP_BIT_CLR;
            oe_reg      <= `SDP_BIT_CLR;
            data_reg    <= `SDP_DATA_RST;
            stby_reg    <= `SDP_CFG_RST;
            sda_out_reg <= `SDP_BIT_CLR;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            sh_reg      <= sh_next;
            cmd_reg     <= cmd_next;
            rw_reg      <= rw_next;
            mack_reg    <= mack_next;
            oe_reg      <= oe_next;
            data_reg    <= data_next;
            stby_reg    <= stby_next;
            // open drain: the line is only ever pulled low
            sda_out_reg <= `SDP_BIT_CLR;
        end
    end

    // no clock output; open drain data only
    assign sda_out    = sda_out_reg;
    assign sda_oe     = oe_reg;
    assign conv_value = data_reg;
    assign standby    = stby_reg;
    assign xfer_state = state_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    wire quiet = !start_det && !stop_det;

    a_idle_release: assert property (
        (state_reg == SDP_IDLE || state_reg == SDP_IGNORE) |-> !oe_reg)
        else $error("data driven while idle");
    a_stop_idle: assert property (
        stop_det |=> (state_reg == SDP_IDLE) && !oe_reg)
        else $error("stop did not idle the port");
    a_addr_ack: assert property (
        (state_reg == SDP_ADDR && scl_fall && byte_done && addr_hit
         && quiet) |=> (state_reg == SDP_ADDR_ACK) && oe_reg)
        else $error("own address not acknowledged");
    a_addr_miss: assert property (
        (state_reg == SDP_ADDR && scl_fall && byte_done && !addr_hit
         && quiet) |=> (state_reg == SDP_IGNORE) && !oe_reg)
        else $error("foreign address acknowledged");
    a_read_dir: assert property (
        (state_reg == SDP_ADDR_ACK && scl_fall && quiet) |=>
        (state_reg == (rw_reg ? SDP_RDATA : SDP_CMD)))
        else $error("direction bit misapplied");
    a_read_msb: assert property (
        (state_reg == SDP_ADDR_ACK && scl_fall && rw_reg && quiet) |=>
        (oe_reg == !$past(read_value[7])))
        else $error("read byte not msb first");
    a_data_write: assert property (
        (state_reg == SDP_WDATA && scl_fall && byte_done && quiet &&
         cmd_reg == `SDP_CMD_DATA) |=> (data_reg == $past(sh_reg)))
        else $error("data register not written");
    a_cfg_write: assert property (
        (state_reg == SDP_WDATA && scl_fall && byte_done && quiet &&
         cmd_reg == `SDP_CMD_CFG) |=>
        (stby_reg == $past(sh_reg[`SDP_CFG_STBY_BIT])) && oe_reg)
        else $error("configuration write not acknowledged");
    a_oe_moves: assert property (
        $changed(oe_reg) |-> $past(scl_fall) || $past(stop_det)
                             || $past(start_det))
        else $error("data changed while clock high");
    a_ack_hold: assert property (
        (state_reg == SDP_CMD_ACK && scl_s) |-> oe_reg)
        else $error("ack released during clock high");
    a_read_nack: assert property (
        (state_reg == SDP_RDATA_ACK && scl_fall && !mack_reg && quiet)
        |=> (state_reg == SDP_IGNORE))
        else $error("read went on after nack");

    c_write_data: cover property (
        state_reg == SDP_WDATA_ACK && cmd_reg == `SDP_CMD_DATA);
    c_read_done: cover property (
        state_reg == SDP_RDATA_ACK ##[1:1000] stop_det);
    c_addr_miss: cover property (state_reg == SDP_IGNORE);
endmodule

// ---- sdp_host_model.sv ----
// host master model driving the two-wire bus
`timescale 1ns/100ps

module sdp_host_model (
    input  wire logic mclk,
    input  wire logic sda_line,
    output logic      scl_drv,
    output logic      sda_low
);
    initial begin
        scl_drv = 1'b1;
        sda_low = 1'b0;
    end

    // master paces the clock in 10 mclk steps, 10 mclk high and 20 mclk low per bit
    task automatic hp();
        repeat (10) @(posedge mclk);
    endtask

    task automatic start();
        sda_low <= 1'b0;
        hp();
        scl_drv <= 1'b1;
        hp();
        sda_low <= 1'b1;
        hp();
        scl_drv <= 1'b0;
        hp();
    endtask

    task automatic stop();
        sda_low <= 1'b1;
        hp();
        scl_drv <= 1'b1;
        hp();
        sda_low <= 1'b0;
        hp();
    endtask

    // data moves while clock low, sampled at end of high
    task automatic bit_xfer(input logic b, output logic r);
        sda_low <= ~b;
        hp();
        scl_drv <= 1'b1;
        hp();
        r = sda_line;
        scl_drv <= 1'b0;
        hp();
    endtask

    // msb first, ninth clock given by the master
    task automatic byte_xfer(input logic [7:0] d, input logic nb,
                             output logic [7:0] r, output logic nr);
        for (int i = 7; i >= 0; i--)
            bit_xfer(d[i], r[i]);
        bit_xfer(nb, nr);
    endtask
endmodule

// ---- sdp_slave_tb.sv ----
// self-checking bench for the two-wire dac slave port
`timescale 1ns/100ps
`include "sdp_params.svh"

module sdp_slave_tb;
    import sdp_pkg::*;
    logic                  mclk;
    logic                  rst_b;
    logic                  scl_drv;
    logic                  sda_low;
    logic                  sda_line;
    logic                  sda_out;
    logic                  sda_oe;
    logic                  standby;
    logic [7:0]            conv_value;
    sdp_state_type         xfer_state;
    int                    n_errors = 0;
    int                    total_checks = 0;
    int                    cycles = 0;
    int                    seed = 52;
    int                    exp_data = 0;
    int                    exp_cfg = 0;

    // open-drain data wire with pull-up
    assign sda_line = !((sda_oe && !sda_out) || sda_low);

    sdp_slave u_sdp_slave (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .scl_in     (scl_drv),
        .sda_in     (sda_line),
        .sda_out    (sda_out),
        .sda_oe     (sda_oe),
        .conv_value (conv_value),
        .standby    (standby),
        .xfer_state (xfer_state)
    );

    sdp_host_model u_sdp_host_model (
        .mclk     (mclk),
        .sda_line (sda_line),
        .scl_drv  (scl_drv),
        .sda_low  (sda_low)
    );

    initial mclk = 1'b0;
    always #4 mclk = ~mclk;

    // whole run needs about 23k cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %0t timeout", $time);
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (n_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] e, input logic [7:0] a,
                        input string m);
        total_checks++;
        if (a !== e) begin
            n_errors++;
            $display("MISMATCH %0t %s exp %h got %h", $time, m, e, a);
        end
    endtask

    task automatic chk1(input logic e, input logic a, input string m);
        total_checks++;
        if (a !== e) begin
            n_errors++;
            $display("MISMATCH %0t %s exp %b got %b", $time, m, e, a);
        end
    endtask

    task automatic settle();
        repeat (6) @(posedge mclk);
        chk1(1'b0, sda_oe, "data not released");
        chk8({4'h0, SDP_IDLE}, {4'h0, xfer_state}, "not idle");
        chk8(8'(exp_data), conv_value, "data reg");
        chk1(exp_cfg[0], standby, "standby bit");
    endtask

    // miss or unknown command must leave registers untouched
    task automatic wr(input logic [6:0] a, input logic [7:0] cmd,
                      input logic [7:0] dq[$]);
        logic [7:0] r;
        logic       n;
        logic       hit;
        hit = (a === `SDP_SLAVE_ADDR);
        u_sdp_host_model.start();
        u_sdp_host_model.byte_xfer({a, 1'b0}, 1'b1, r, n);
        chk1(!hit, n, "addr ack");
        u_sdp_host_model.byte_xfer(cmd, 1'b1, r, n);
        chk1(!hit, n, "cmd ack");
        foreach (dq[i]) begin
            u_sdp_host_model.byte_xfer(dq[i], 1'b1, r, n);
            chk1(!(hit && cmd < 8'h02), n, "data ack");
            if (hit && cmd == 8'h00)
                exp_data = dq[i];
            if (hit && cmd == 8'h01)
                exp_cfg = dq[i] & 1;
        end
        u_sdp_host_model.stop();
        settle();
    endtask

    task automatic rd(input logic [7:0] cmd);
        logic [7:0] r;
        logic       n;
        int         e;
        e = (cmd == 8'h00) ? exp_data : (cmd == 8'h01) ? exp_cfg : 0;
        u_sdp_host_model.start();
        u_sdp_host_model.byte_xfer({`SDP_SLAVE_ADDR, 1'b0}, 1'b1, r, n);
        u_sdp_host_model.byte_xfer(cmd, 1'b1, r, n);
        chk1(1'b0, n, "cmd ack");
        u_sdp_host_model.start();
        u_sdp_host_model.byte_xfer({`SDP_SLAVE_ADDR, 1'b1}, 1'b1, r, n);
        chk1(1'b0, n, "read addr ack");
        u_sdp_host_model.byte_xfer(8'hff, 1'b1, r, n);
        chk8(8'(e), r, "read byte");
        u_sdp_host_model.stop();
        settle();
    endtask

    initial begin
        logic [7:0] q[$];
        logic [7:0] r;
        logic       n;
        rst_b = 1'b0;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        chk8(8'h00, conv_value, "data reset");
        chk1(1'b0, standby, "cfg reset");
        rd(8'h00);
        rd(8'h01);
        // own address clocked in with no start before it
        u_sdp_host_model.byte_xfer({`SDP_SLAVE_ADDR, 1'b0}, 1'b1, r, n);
        chk1(1'b1, n, "ack without start");
        u_sdp_host_model.stop();
        settle();
        for (int k = 0; k < 6; k++) begin
            q = {8'($random(seed)), 8'($random(seed))};
            wr(`SDP_SLAVE_ADDR, 8'(k % 3), q);
            rd(8'(k % 3));
        end
        q = {8'h00, 8'hff};
        wr(`SDP_SLAVE_ADDR, 8'h01, q);
        rd(8'h01);
        wr(`SDP_SLAVE_ADDR, 8'h00, q);
        q = {8'h5a};
        wr(7'h49, 8'h00, q);
        wr(7'h08, 8'h01, q);
        rd(8'h00);
        print_verdict();
    end
endmodule
